/* File: hdl/smc_pkg.sv */
package smc_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CMD     = 8'h00;
  localparam logic [7:0] ADDR_CFG     = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_OSTWAIT = 8'h0c;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CMD_HALT_BIT    = 0;
  localparam int CMD_STOP_BIT    = 1;
  localparam int CFG_CLKSRC_LSB  = 0;
  localparam int CFG_LPSEL_BIT   = 3;
  localparam int CFG_WUTSEL_BIT  = 4;
  localparam int CFG_SNZEN_BIT   = 5;
  localparam int CFG_CMPEXT_BIT  = 6;
  localparam int OPT_WDSTBY_BIT  = 0;
  localparam int OPT_WDEN_BIT    = 4;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [6:0]  CFG_RESET     = 7'h00;
  localparam int          CLK_MHZ       = 50;
  localparam int          OST_WAIT_US   = 65;
  localparam int          OST_CYCLES    = OST_WAIT_US * CLK_MHZ;
  localparam logic [15:0] OSTWAIT_RESET = 16'(OST_CYCLES);

  // ****************************************************************
  // Peripheral gate indices
  // ****************************************************************
  localparam int PG_TAU  = 0;
  localparam int PG_SER  = 1;
  localparam int PG_MDA  = 2;
  localparam int PG_DMA  = 3;
  localparam int PG_ADC  = 4;
  localparam int PG_IIC  = 5;
  localparam int PG_SCU  = 6;
  localparam int PG_CMP  = 7;
  localparam int PG_FMC  = 8;
  localparam int PG_HCRC = 9;
  localparam int PG_NUM  = 10;

  typedef enum logic [1:0] {
    SRC_HOCO,
    SRC_XTAL,
    SRC_EXT,
    SRC_SUB
  } smc_src_e;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_OSTWAIT,
    ST_AUTONOMOUS_WAKE
  } smc_state_e;

endpackage

/* File: hdl/smc_axil.sv */
`timescale 1ns/1ns
module smc_axil
  import smc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok,
  input  wire logic        wr_ok
);

  // ****************************************************************
  // Write channel: capture address and data in either order
  // ****************************************************************
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_q      <= 8'h00;
      wr_data   <= 32'h0;
      wr_strb   <= 4'h0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= 2'b00;
      wr_en     <= 1'b0;
    end else begin
      wr_en     <= 1'b0;
      s_awready <= !aw_held && !s_bvalid && !s_awready;
      s_wready  <= !w_held && !s_bvalid && !s_wready;
      if (s_awvalid && s_awready) begin
        aw_held   <= 1'b1;
        aw_q      <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_held   <= 1'b1;
        wr_data  <= s_wdata;
        wr_strb  <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (aw_held && w_held && !s_bvalid) begin
        wr_en    <= 1'b1;
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= wr_ok ? 2'b00 : 2'b10;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  assign wr_addr = aw_q;

  // ****************************************************************
  // Read channel: one read at a time
  // ****************************************************************
  logic rd_pend;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0;
      s_rresp   <= 2'b00;
      rd_addr   <= 8'h00;
      rd_pend   <= 1'b0;
    end else begin
      s_arready <= !s_rvalid && !rd_pend && !s_arready;
      rd_pend   <= 1'b0;
      if (s_arvalid && s_arready) begin
        s_arready <= 1'b0;
        rd_addr   <= s_araddr;
        rd_pend   <= 1'b1;
      end
      // Data is decoded one cycle after the address lands, so it stands with rvalid
      if (rd_pend) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_ok ? rd_data : 32'h0;
        s_rresp  <= rd_ok ? 2'b00 : 2'b10;
      end
      if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* File: hdl/smc_gate.sv */
`timescale 1ns/1ns
module smc_gate
  import smc_pkg::*;
(
  input  wire logic              in_halt,
  input  wire logic              in_stop,
  input  wire logic              in_autonomous_wake,
  input  wire logic [1:0]        src,
  input  wire logic              low_power_sel,
  input  wire logic              cmp_ext_ref,
  output logic [PG_NUM-1:0]      gate_en
);

  // ****************************************************************
  // Per-peripheral clock enable from mode and clock source
  // ****************************************************************
  logic from_sub;

  assign from_sub = (src == SRC_SUB);

  always_comb begin
    gate_en = '1;
    if (in_halt && from_sub) begin
      gate_en[PG_TAU]  = !low_power_sel;
      gate_en[PG_SER]  = !low_power_sel;
      gate_en[PG_MDA]  = !low_power_sel;
      gate_en[PG_DMA]  = !low_power_sel;
      gate_en[PG_ADC]  = 1'b0;
      gate_en[PG_IIC]  = 1'b0;
      gate_en[PG_SCU]  = 1'b0;
      gate_en[PG_CMP]  = cmp_ext_ref;
      gate_en[PG_HCRC] = 1'b0;
    end
    if (in_halt && (from_sub || src == SRC_HOCO)) begin
      gate_en[PG_FMC] = 1'b0;
    end
    if (in_stop || in_autonomous_wake) begin
      gate_en          = '0;
      gate_en[PG_ADC]  = in_autonomous_wake;
      gate_en[PG_SER]  = in_autonomous_wake;
      gate_en[PG_CMP]  = cmp_ext_ref;
    end
  end

endmodule

/* File: hdl/smc_top.sv */
`timescale 1ns/1ns
// Function
// - Halt gates CPU clock, selected oscillator keeps running
// - Stop halts high-speed oscillators entirely
// - Interrupt exits stop, crystal waits stabilization
// - Serial, RTC or interval timer trigger enters autonomous wake from HOCO stop
// - Standby preserves registers and port latches
// - Pending unmasked interrupt blocks halt entry
// - Low-speed oscillator run per select/options
// - Halt from main keeps active source only
// - Halt from subsystem disables main sources
// - Halt stops CPU and flash, keeps latches
// - Sub halt: timer/serial/muldiv/DMA per low-power
// - Sub halt: ADC/I2C/smartcard off, comparator conditional
// - Frequency measurement off for internal/sub halt
// - Guards act only on DMA during halt
// - CRC on RAM only with DMA; fast CRC off in sub halt
// - Device stops listed functions on entry
// - Unmasked interrupt releases halt
// - Reset releases halt to reset vector
module smc_top
  import smc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axil_awaddr,
  input  wire logic              s_axil_awvalid,
  output logic                   s_axil_awready,
  input  wire logic [31:0]       s_axil_wdata,
  input  wire logic [3:0]        s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output logic                   s_axil_wready,
  output logic [1:0]             s_axil_bresp,
  output logic                   s_axil_bvalid,
  input  wire logic              s_axil_bready,
  input  wire logic [7:0]        s_axil_araddr,
  input  wire logic              s_axil_arvalid,
  output logic                   s_axil_arready,
  output logic [31:0]            s_axil_rdata,
  output logic [1:0]             s_axil_rresp,
  output logic                   s_axil_rvalid,
  input  wire logic              s_axil_rready,
  input  wire logic              halt_exec,
  input  wire logic              stop_exec,
  input  wire logic              irq_pending,
  input  wire logic              clocked_serial_channel_rx,
  input  wire logic              async_serial_channel_rx,
  input  wire logic              rtc_interrupt,
  input  wire logic              interval_timer_interrupt,
  input  wire logic              wake_done,
  input  wire logic [7:0]        option_byte,
  output logic                   cpu_clk_en,
  output logic                   flash_en,
  output logic                   hoco_en,
  output logic                   main_crystal_clock_en,
  output logic                   ext_main_en,
  output logic                   sub_crystal_clock_en,
  output logic                   ext_sub_en,
  output logic                   lsoc_en,
  output logic                   port_latch_hold,
  output logic                   dma_only_guard,
  output logic                   wake_release,
  output logic [PG_NUM-1:0]      periph_clk_en
);

  // ****************************************************************
  // Input synchronisers for pins from outside the domain
  // ****************************************************************
  logic [3:0] wake_meta;
  logic [3:0] wake_sync;
  logic [7:0] opt_meta;
  logic [7:0] opt_sync;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_meta <= 4'h0;
      wake_sync <= 4'h0;
      opt_meta  <= 8'h00;
      opt_sync  <= 8'h00;
    end else begin
      wake_meta <= {interval_timer_interrupt, rtc_interrupt, async_serial_channel_rx, clocked_serial_channel_rx};
      wake_sync <= wake_meta;
      opt_meta  <= option_byte;
      opt_sync  <= opt_meta;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        wr_ok;
  logic [6:0]  cfg;
  logic [15:0] ost_wait;
  logic        sw_halt;
  logic        sw_stop;
  smc_state_e  state;
  logic [15:0] ost_cnt;
  logic [1:0]  src;

  assign src = cfg[CFG_CLKSRC_LSB +: 2];

  smc_axil u_axil (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_axil_awaddr),
    .s_awvalid (s_axil_awvalid),
    .s_awready (s_axil_awready),
    .s_wdata   (s_axil_wdata),
    .s_wstrb   (s_axil_wstrb),
    .s_wvalid  (s_axil_wvalid),
    .s_wready  (s_axil_wready),
    .s_bresp   (s_axil_bresp),
    .s_bvalid  (s_axil_bvalid),
    .s_bready  (s_axil_bready),
    .s_araddr  (s_axil_araddr),
    .s_arvalid (s_axil_arvalid),
    .s_arready (s_axil_arready),
    .s_rdata   (s_axil_rdata),
    .s_rresp   (s_axil_rresp),
    .s_rvalid  (s_axil_rvalid),
    .s_rready  (s_axil_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok),
    .wr_ok     (wr_ok)
  );

  assign wr_ok = (wr_addr == ADDR_CMD) || (wr_addr == ADDR_CFG) || (wr_addr == ADDR_OSTWAIT);

  always_comb begin
    rd_ok   = 1'b1;
    rd_data = 32'h0;
    unique case (rd_addr)
      ADDR_CMD:     rd_data = 32'h0;
      ADDR_CFG:     rd_data = {25'h0, cfg};
      ADDR_STATUS:  rd_data = {13'h0, ost_cnt, 3'(state)};
      ADDR_OSTWAIT: rd_data = {16'h0, ost_wait};
      default:      rd_ok   = 1'b0;
    endcase
  end

  // Configuration survives every standby mode untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg      <= CFG_RESET;
      ost_wait <= OSTWAIT_RESET;
    end else if (wr_en && state == ST_RUN) begin
      if (wr_addr == ADDR_CFG && wr_strb[0]) begin
        cfg <= wr_data[6:0];
      end
      if (wr_addr == ADDR_OSTWAIT) begin
        if (wr_strb[0]) begin
          ost_wait[7:0] <= wr_data[7:0];
        end
        if (wr_strb[1]) begin
          ost_wait[15:8] <= wr_data[15:8];
        end
      end
    end
  end

  // Software-issued entry commands are one-cycle pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_halt <= 1'b0;
      sw_stop <= 1'b0;
    end else begin
      sw_halt <= wr_en && wr_addr == ADDR_CMD && wr_strb[0] && wr_data[CMD_HALT_BIT];
      sw_stop <= wr_en && wr_addr == ADDR_CMD && wr_strb[0] && wr_data[CMD_STOP_BIT];
    end
  end

  // ****************************************************************
  // Standby sequencer
  // ****************************************************************
  logic go_halt;
  logic go_stop;
  logic autonomous_wake_req;

  assign go_halt    = halt_exec || sw_halt;
  assign go_stop    = (stop_exec || sw_stop) && src != SRC_SUB;
  assign autonomous_wake_req = cfg[CFG_SNZEN_BIT] && src == SRC_HOCO && (|wake_sync);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state   <= ST_RUN;
      ost_cnt <= 16'h0;
    end else begin
      unique case (state)
        ST_RUN: begin
          if (go_halt && !irq_pending) begin
            state <= ST_HALT;
          end else if (go_stop && !irq_pending) begin
            state <= ST_STOP;
          end
        end
        ST_HALT: begin
          if (irq_pending) begin
            state <= ST_RUN;
          end
        end
        ST_STOP: begin
          if (irq_pending) begin
            if (src == SRC_XTAL) begin
              state   <= ST_OSTWAIT;
              ost_cnt <= ost_wait;
            end else begin
              state <= ST_RUN;
            end
          end else if (autonomous_wake_req) begin
            state <= ST_AUTONOMOUS_WAKE;
          end
        end
        ST_OSTWAIT: begin
          if (ost_cnt <= 16'h1) begin
            ost_cnt <= 16'h0;
            state   <= ST_RUN;
          end else begin
            ost_cnt <= ost_cnt - 16'h1;
          end
        end
        ST_AUTONOMOUS_WAKE: begin
          if (irq_pending) begin
            state <= ST_RUN;
          end else if (wake_done) begin
            state <= ST_STOP;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Clock and function control outputs
  // ****************************************************************
  logic              in_halt;
  logic              in_stop;
  logic              in_autonomous_wake;
  logic              lsoc_run;
  logic [PG_NUM-1:0] gate_en;

  assign in_halt   = (state == ST_HALT);
  assign in_stop   = (state == ST_STOP) || (state == ST_OSTWAIT);
  assign in_autonomous_wake = (state == ST_AUTONOMOUS_WAKE);
  assign lsoc_run  = cfg[CFG_WUTSEL_BIT] || (opt_sync[OPT_WDEN_BIT] && opt_sync[OPT_WDSTBY_BIT]);

  smc_gate u_gate (
    .in_halt       (in_halt),
    .in_stop       (in_stop),
    .in_autonomous_wake     (in_autonomous_wake),
    .src           (src),
    .low_power_sel (cfg[CFG_LPSEL_BIT]),
    .cmp_ext_ref   (cfg[CFG_CMPEXT_BIT]),
    .gate_en       (gate_en)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_clk_en            <= 1'b1;
      flash_en              <= 1'b1;
      hoco_en               <= 1'b1;
      main_crystal_clock_en <= 1'b0;
      ext_main_en           <= 1'b0;
      sub_crystal_clock_en  <= 1'b0;
      ext_sub_en            <= 1'b0;
      lsoc_en               <= 1'b0;
      port_latch_hold       <= 1'b0;
      dma_only_guard        <= 1'b0;
      wake_release          <= 1'b0;
      periph_clk_en         <= '1;
    end else begin
      cpu_clk_en            <= (state == ST_RUN) && !(go_halt && !irq_pending);
      flash_en              <= (state == ST_RUN);
      hoco_en               <= !in_stop && (!in_halt || src == SRC_HOCO) || in_autonomous_wake;
      main_crystal_clock_en <= (state == ST_OSTWAIT) || (!in_stop && !in_autonomous_wake && (!in_halt || src == SRC_XTAL));
      ext_main_en           <= !in_stop && !in_autonomous_wake && (!in_halt || src == SRC_EXT);
      sub_crystal_clock_en  <= src == SRC_SUB;
      ext_sub_en            <= 1'b0;
      lsoc_en               <= (state == ST_RUN) || lsoc_run;
      port_latch_hold       <= (state != ST_RUN);
      dma_only_guard        <= in_halt;
      wake_release          <= (state != ST_RUN) && irq_pending;
      periph_clk_en         <= gate_en;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_halt_block: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_RUN && irq_pending) |=> state != ST_HALT) else $error("halt entered with pending irq");
  a_stop_sub: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_RUN && src == SRC_SUB && !go_halt) |=> state != ST_STOP) else $error("stop from subclock");
  a_halt_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    (in_halt && irq_pending) |=> state == ST_RUN) else $error("halt not released");
  a_cpu_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    in_halt |=> !cpu_clk_en) else $error("cpu clock runs in halt");
  a_stop_osc: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_STOP) |=> !hoco_en) else $error("oscillator runs in stop");
  a_ost_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_STOP && irq_pending && src == SRC_XTAL) |=> state == ST_OSTWAIT) else $error("no stabilization");
  a_cfg_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (state != ST_RUN) |=> $stable(cfg)) else $error("config changed in standby");
  a_sub_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (in_halt && src == SRC_SUB) |=> !periph_clk_en[PG_ADC] && !periph_clk_en[PG_IIC]) else $error("adc on");
  a_flash_off: assert property (@(posedge aclk) disable iff (!aresetn)
    in_halt |=> !flash_en) else $error("flash runs in halt");
  a_dma_guard: assert property (@(posedge aclk) disable iff (!aresetn)
    in_halt |=> dma_only_guard) else $error("guard not limited to dma in halt");
  a_sub_mains: assert property (@(posedge aclk) disable iff (!aresetn)
    (in_halt && src == SRC_SUB) |=> !hoco_en && !main_crystal_clock_en && !ext_main_en) else $error("main osc on");
  a_lsoc_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (state != ST_RUN && !cfg[CFG_WUTSEL_BIT] && !opt_sync[OPT_WDEN_BIT]) |=> !lsoc_en) else $error("lsoc runs");
  a_stop_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    in_stop |=> !periph_clk_en[PG_TAU] && !periph_clk_en[PG_DMA]) else $error("peripheral clocked in stop");
  a_ost_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_OSTWAIT && ost_cnt > 16'h1) |=> state == ST_OSTWAIT) else $error("stabilization cut short");
  c_halt: cover property (@(posedge aclk) disable iff (!aresetn) state == ST_RUN ##1 state == ST_HALT);
  c_stop_wait: cover property (@(posedge aclk) disable iff (!aresetn) state == ST_OSTWAIT ##1 state == ST_RUN);
  c_autonomous_wake: cover property (@(posedge aclk) disable iff (!aresetn) state == ST_AUTONOMOUS_WAKE ##1 state == ST_STOP);
  c_halt_refused: cover property (@(posedge aclk) disable iff (!aresetn) state == ST_RUN && go_halt && irq_pending);
  c_sub_halt: cover property (@(posedge aclk) disable iff (!aresetn) in_halt && src == SRC_SUB);

endmodule

/* File: test/smc_host_model.sv */
`timescale 1ns/1ns
// ****
// Core and interrupt controller stand-in
// ****
module smc_host_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic do_halt,
  input  wire logic do_stop,
  input  wire logic irq_req,
  output logic      halt_exec,
  output logic      stop_exec,
  output logic      irq_pending
);
  logic ph;
  logic ps;
  always_ff @(posedge aclk) begin
    ph          <= aresetn & do_halt;
    ps          <= aresetn & do_stop;
    halt_exec   <= aresetn & do_halt & ~ph;
    stop_exec   <= aresetn & do_stop & ~ps;
    irq_pending <= aresetn & irq_req;
  end
endmodule

/* File: test/test_standby_mode_controller.sv */
`timescale 1ns/1ns
module test_standby_mode_controller
  import smc_pkg::*;
;
  logic        aclk, aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready;
  logic        s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [7:0]  s_axil_awaddr, s_axil_araddr, option_byte;
  logic [31:0] s_axil_wdata, s_axil_rdata, rv;
  logic [3:0]  s_axil_wstrb, trig;
  logic [1:0]  s_axil_bresp, s_axil_rresp, rr;
  logic        halt_exec, stop_exec, irq_pending, wake_done, do_halt, do_stop, irq_req;
  logic        cpu_clk_en, flash_en, hoco_en, main_crystal_clock_en, ext_main_en, sub_crystal_clock_en;
  logic        ext_sub_en, lsoc_en, port_latch_hold, dma_only_guard, wake_release;
  logic [9:0]  periph_clk_en;
  int          errors, samples_checked;

  smc_host_model host (.aclk, .aresetn, .do_halt, .do_stop, .irq_req, .halt_exec, .stop_exec, .irq_pending);

  smc_top uut (
    .aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb,
    .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
    .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
    .halt_exec, .stop_exec, .irq_pending, .clocked_serial_channel_rx(trig[0]),
    .async_serial_channel_rx(trig[1]), .rtc_interrupt(trig[2]), .interval_timer_interrupt(trig[3]),
    .wake_done, .option_byte, .cpu_clk_en, .flash_en, .hoco_en, .main_crystal_clock_en, .ext_main_en,
    .sub_crystal_clock_en, .ext_sub_en, .lsoc_en, .port_latch_hold, .dma_only_guard, .wake_release,
    .periph_clk_en
  );

  always #10 aclk = ~aclk;

  // ****
  // Report and bus tasks
  // ****
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  task automatic bound(input int n);
    if (n >= 60) begin
      $display("wait ran out at %0t", $time);
      errors++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit ad;
    bit wd;
    n = 0;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    s_axil_awaddr  <= a;
    s_axil_wdata   <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid  <= 1'b1;
    s_axil_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axil_awready && !ad) begin
        s_axil_awvalid <= 1'b0;
        ad = 1;
      end
      if (s_axil_wready && !wd) begin
        s_axil_wvalid <= 1'b0;
        wd = 1;
      end
    end while (!(ad && wd) && n < 60);
    while (!s_axil_bvalid && n < 60) begin
      @(posedge aclk);
      n++;
    end
    rr = s_axil_bresp;
    s_axil_bready <= 1'b0;
    bound(n);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axil_araddr  <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axil_arready) begin
        s_axil_arvalid <= 1'b0;
      end
    end while (!s_axil_rvalid && n < 60);
    rv = s_axil_rdata;
    rr = s_axil_rresp;
    s_axil_rready <= 1'b0;
    bound(n);
  endtask

  task automatic poll(input logic [2:0] st);
    int k;
    k = 0;
    do begin
      rd(ADDR_STATUS);
      k++;
    end while (rv[2:0] !== st && k < 60);
    bound(k);
    chk(rv[2:0], st);
  endtask

  task automatic hit(input logic h, input logic s);
    @(posedge aclk);
    do_halt <= h;
    do_stop <= s;
    @(posedge aclk);
    do_halt <= 1'b0;
    do_stop <= 1'b0;
  endtask

  task automatic wake;
    irq_req <= 1'b1;
    poll(ST_RUN);
    irq_req <= 1'b0;
  endtask

  task automatic halt_cfg(input logic [31:0] c);
    wr(ADDR_CFG, c);
    hit(1'b1, 1'b0);
    poll(ST_HALT);
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    {aclk, aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = '0;
    {s_axil_awaddr, s_axil_araddr, option_byte, s_axil_wdata, trig, do_halt, do_stop, irq_req} = '0;
    wake_done = 1'b0;
    s_axil_wstrb = 4'hf;
    errors = 0;
    samples_checked = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CFG);
    chk(rv, 32'h0);
    rd(ADDR_OSTWAIT);
    chk(rv, 32'(OSTWAIT_RESET));
    rd(8'h10);
    chk({rv[29:0], rr}, 32'h2);
    wr(ADDR_OSTWAIT, 32'd40);
    chk(rr, 2'h0);
    wr(8'h10, 32'h1);
    chk(rr, 2'h2);
    $display("test reset and map done");
    halt_cfg(32'h0);
    chk({cpu_clk_en, flash_en, hoco_en, main_crystal_clock_en, lsoc_en, port_latch_hold, dma_only_guard}, 7'h13);
    chk({periph_clk_en[PG_FMC], periph_clk_en[PG_TAU], periph_clk_en[PG_ADC]}, 3'h3);
    irq_req <= 1'b1;
    poll(ST_RUN);
    hit(1'b1, 1'b0);
    rd(ADDR_STATUS);
    chk(rv[2:0], ST_RUN);
    irq_req <= 1'b0;
    $display("test main halt done");
    halt_cfg(32'h0b);
    chk({hoco_en, main_crystal_clock_en, ext_main_en, sub_crystal_clock_en, periph_clk_en}, 14'h0400);
    chk(ext_sub_en, 1'b0);
    wake();
    halt_cfg(32'h43);
    chk(periph_clk_en, 10'h08f);
    wake();
    wr(ADDR_CMD, 32'h2);
    rd(ADDR_STATUS);
    chk(rv[2:0], ST_RUN);
    $display("test sub halt done");
    halt_cfg(32'h10);
    chk(lsoc_en, 1'b1);
    wake();
    option_byte <= 8'h11;
    halt_cfg(32'h0);
    chk(lsoc_en, 1'b1);
    wake();
    $display("test low speed osc done");
    wr(ADDR_CFG, 32'h01);
    hit(1'b0, 1'b1);
    poll(ST_STOP);
    chk({cpu_clk_en, hoco_en, main_crystal_clock_en, port_latch_hold}, 4'h1);
    irq_req <= 1'b1;
    poll(ST_OSTWAIT);
    chk(wake_release, 1'b1);
    poll(ST_RUN);
    irq_req <= 1'b0;
    $display("test deep sleep done");
    wr(ADDR_CFG, 32'h20);
    for (int i = 0; i < 4; i++) begin
      hit(1'b0, 1'b1);
      poll(ST_STOP);
      trig[i] <= 1'b1;
      poll(ST_AUTONOMOUS_WAKE);
      chk(cpu_clk_en, 1'b0);
      trig[i] <= 1'b0;
      repeat (4) @(posedge aclk);
      wake_done <= 1'b1;
      @(posedge aclk);
      wake_done <= 1'b0;
      poll(ST_STOP);
      wake();
    end
    $display("test autonomous wake done");
    tally_and_finish();
  end
endmodule
